// [hw/epd_top.sv]
// Encoder pulse divider: three channel dividers and a Wishbone slave.
// Assumes encoder and switch inputs synchronous to mclk (200 MHz) and an
// external pull-up per divided output.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "epd_params.svh"

// ==========================================================================
// One channel divider: toggles its output every setting rising edges
module epd_chan (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [7:0] setting,
    input wire logic enc_in,
    output logic level
);
    logic prev;
    logic [7:0] cnt;
    logic div_lvl;
    logic rise;
    logic wrap;
    logic bypass;
    logic [7:0] next_cnt;
    logic next_div_lvl;
    logic next_level;

    // Edge detect and terminal count
    assign rise = enc_in & ~prev;
    assign wrap = ({1'b0, cnt} + `EPD_CNT_STEP) >= {1'b0, setting}; // RULE2
    assign bypass = setting == `EPD_SET_NONE; // RULE3

    // Half the ratio of rising edges per output toggle
    assign next_cnt = !enable ? 8'h00 :
                      !rise ? cnt :
                      wrap ? 8'h00 : cnt + 8'h01; // RULE7
    assign next_div_lvl = !enable ? 1'b0 :
                          (rise && wrap) ? ~div_lvl : div_lvl; // RULE7
    // Disabled output released; zero setting passes input through
    assign next_level = !enable ? 1'b1 :
                        bypass ? enc_in : div_lvl; // RULE3

    // Channel state
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prev <= 1'b0;
            cnt <= 8'h00;
            div_lvl <= 1'b0;
            level <= 1'b1;
        end else begin
            prev <= enc_in;
            cnt <= next_cnt;
            div_lvl <= next_div_lvl;
            level <= next_level;
        end
    end
endmodule : epd_chan

// Overview of operation
// RULE1: Eight switches form the setting; switch one is bit zero, on is one.
// RULE2: Output frequency is input frequency divided by twice the setting.
// RULE3: A zero setting passes encoder pulses straight through, undivided.
// RULE4: All switches on gives ratio 510, the largest available.
// RULE5: Divided index and both phases leave on three open-collector pins.
// RULE6: Encoder rate at most 300 kHz differential, 80 kHz single-ended.
// RULE7: All channels share the ratio; each toggles after half-ratio rises.
module epd_top
    import epd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    input wire logic [7:0] dip_sw,
    output logic div_out_first_phase,
    output logic div_out_first_phase_oe,
    input wire logic div_out_first_phase_in,
    output logic div_out_second_phase,
    output logic div_out_second_phase_oe,
    input wire logic div_out_second_phase_in,
    output logic div_out_index,
    output logic div_out_index_oe,
    input wire logic div_out_index_in,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [31:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack
);
    epd_ctrl_type ctrl;
    epd_chan_type enc;
    epd_chan_type lvl;
    epd_chan_type pin;
    logic [7:0] setting;
    logic req;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_ctrl;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] next_dat_r;
    logic [31:0] ctrl_rst;

    // Reset image of the control word, sliced per field below
    assign ctrl_rst = `EPD_CTRL_RESET;
    // ======================================================================
    // Channel inputs and the shared setting
    assign enc.first_phase = enc_a;
    assign enc.second_phase = enc_b;
    assign enc.index = enc_z;
    // Switch k drives bit k-1; software may override for test
    assign setting = ctrl.override ? ctrl.setting : dip_sw; // RULE1 RULE4

    // One divider per channel, same ratio for all
    epd_chan u_first (
        .mclk(mclk),
        .rst_b(rst_b),
        .enable(ctrl.enable),
        .setting(setting),
        .enc_in(enc.first_phase),
        .level(lvl.first_phase)
    ); // RULE7
    epd_chan u_second (
        .mclk(mclk),
        .rst_b(rst_b),
        .enable(ctrl.enable),
        .setting(setting),
        .enc_in(enc.second_phase),
        .level(lvl.second_phase)
    ); // RULE7
    epd_chan u_index (
        .mclk(mclk),
        .rst_b(rst_b),
        .enable(ctrl.enable),
        .setting(setting),
        .enc_in(enc.index),
        .level(lvl.index)
    ); // RULE7

    // ======================================================================
    // Open-collector drive: pull low while the level is low
    assign div_out_first_phase = 1'b0; // RULE5
    assign div_out_first_phase_oe = ~lvl.first_phase; // RULE5
    assign div_out_second_phase = 1'b0; // RULE5
    assign div_out_second_phase_oe = ~lvl.second_phase; // RULE5
    assign div_out_index = 1'b0; // RULE5
    assign div_out_index_oe = ~lvl.index; // RULE5
    assign pin.first_phase = div_out_first_phase_in;
    assign pin.second_phase = div_out_second_phase_in;
    assign pin.index = div_out_index_in;

    // ======================================================================
    // Bus decode
    assign req = wb_cyc & wb_stb & ~wb_ack;
    assign hit_ctrl = wb_adr == `EPD_REG_CTRL;
    assign hit_stat = wb_adr == `EPD_REG_STAT;
    assign wr_ctrl = req & wb_we & hit_ctrl;

    // Register images; unused bits read zero
    always_comb begin
        ctrl_word = `EPD_WORD_ZERO;
        ctrl_word[`EPD_CTRL_EN_BIT] = ctrl.enable;
        ctrl_word[`EPD_CTRL_OVR_BIT] = ctrl.override;
        ctrl_word[`EPD_CTRL_SET_MSB:`EPD_CTRL_SET_LSB] = ctrl.setting;
        stat_word = `EPD_WORD_ZERO;
        stat_word[`EPD_STAT_SET_MSB:`EPD_STAT_SET_LSB] = setting;
        stat_word[`EPD_STAT_LVL_MSB:`EPD_STAT_LVL_LSB] = lvl;
        stat_word[`EPD_STAT_PIN_MSB:`EPD_STAT_PIN_LSB] = pin;
        stat_word[`EPD_STAT_ENC_MSB:`EPD_STAT_ENC_LSB] = enc;
    end

    // Read mux; unmapped addresses read zero
    assign next_dat_r = !req ? wb_dat_r :
                        hit_ctrl ? ctrl_word :
                        hit_stat ? stat_word : `EPD_WORD_ZERO;

    // Bus answer, one cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_ack <= 1'b0;
            wb_dat_r <= `EPD_WORD_ZERO;
        end else begin
            wb_ack <= req;
            wb_dat_r <= next_dat_r;
        end
    end

    // Control register, byte lanes honoured
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrl.enable <= ctrl_rst[`EPD_CTRL_EN_BIT];
            ctrl.override <= ctrl_rst[`EPD_CTRL_OVR_BIT];
            ctrl.setting <= ctrl_rst[`EPD_CTRL_SET_MSB:`EPD_CTRL_SET_LSB];
        end else begin
            if (wr_ctrl && wb_sel[`EPD_LANE_CTRL]) begin
                ctrl.enable <= wb_dat_w[`EPD_CTRL_EN_BIT];
                ctrl.override <= wb_dat_w[`EPD_CTRL_OVR_BIT];
            end
            if (wr_ctrl && wb_sel[`EPD_LANE_SET]) begin
                ctrl.setting <= wb_dat_w[`EPD_CTRL_SET_MSB:`EPD_CTRL_SET_LSB];
            end
        end
    end
endmodule : epd_top

`default_nettype wire

// [shared/epd_params.svh]
// Named constants for the encoder pulse divider: register map, field
// positions, reset values.
// Assumes inclusion by bare name from design and bench files.
`ifndef EPD_PARAMS_SVH
`define EPD_PARAMS_SVH

// ==========================================================================
// Register byte addresses
`define EPD_REG_CTRL 32'h0000_0000
`define EPD_REG_STAT 32'h0000_0004

// ==========================================================================
// Control register fields
`define EPD_CTRL_EN_BIT 0
`define EPD_CTRL_OVR_BIT 1
`define EPD_CTRL_SET_LSB 8
`define EPD_CTRL_SET_MSB 15
`define EPD_CTRL_RESET 32'h0000_0001

// ==========================================================================
// Status register fields
`define EPD_STAT_SET_LSB 0
`define EPD_STAT_SET_MSB 7
`define EPD_STAT_LVL_LSB 8
`define EPD_STAT_LVL_MSB 10
`define EPD_STAT_PIN_LSB 11
`define EPD_STAT_PIN_MSB 13
`define EPD_STAT_ENC_LSB 14
`define EPD_STAT_ENC_MSB 16

// ==========================================================================
// Byte lanes and setting values
`define EPD_LANE_CTRL 0
`define EPD_LANE_SET 1
`define EPD_SET_NONE 8'h00
`define EPD_CNT_STEP 9'h001
`define EPD_WORD_ZERO 32'h0000_0000

`endif

// [shared/epd_pkg.sv]
// Types shared by the encoder pulse divider and its bench.
// Assumes epd_params.svh supplies the numeric constants.
package epd_pkg;

    // ======================================================================
    // One bit per pulse channel
    typedef struct packed {
        logic index;
        logic second_phase;
        logic first_phase;
    } epd_chan_type;

    // ======================================================================
    // Software control fields
    typedef struct packed {
        logic [7:0] setting;
        logic override;
        logic enable;
    } epd_ctrl_type;

endpackage : epd_pkg

// [sim/epd_enc_model.sv]
// Encoder and pull-up model facing the pulse divider.
// Assumes a one-cycle start pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module epd_enc_model
    import epd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [11:0] periods,
    input wire epd_chan_type oe,
    output var epd_chan_type enc,
    output var epd_chan_type pin,
    output logic busy
);
    logic [14:0] step;
    // Eight cycles a period, each phase level held four cycles
    always_ff @(posedge mclk) begin
        if (!rst_b) step <= 15'h0000;
        else if (start) step <= {periods, 3'h0};
        else if (busy) step <= step - 15'h0001;
    end
    // Quadrature phases and an index pulse every period
    assign busy = step != 15'h0000;
    assign enc.first_phase = busy & step[2];
    assign enc.second_phase = busy & (step[2] ^ step[1]);
    assign enc.index = busy & step[2] & step[1];
    // Pull-ups lift each pin while it is released
    assign pin = ~oe;
endmodule : epd_enc_model
`default_nettype wire

// [sim/epd_monitor.sv]
// Port checker for the encoder pulse divider.
// Assumes a bind to epd_top; override is set only while the encoder idles.
`timescale 1ns/1ps
`default_nettype none
module epd_monitor (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    input wire logic [7:0] dip_sw,
    input wire logic div_out_first_phase,
    input wire logic div_out_second_phase,
    input wire logic div_out_index,
    input wire logic div_out_first_phase_oe,
    input wire logic div_out_second_phase_oe,
    input wire logic div_out_index_oe,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_ack
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // One ack pulse, then quiet
    sequence s_ack_once;
        ##1 wb_ack ##1 !wb_ack;
    endsequence
    a_ack_single_pulse: assert property (wb_cyc && wb_stb && !wb_ack
        |-> s_ack_once) else $error("ack not one cycle after request");
    a_ack_after_req: assert property (wb_ack
        |-> $past(wb_cyc) && $past(wb_stb) && !$past(wb_ack))
        else $error("ack without a request");
    a_pins_held_low: assert property (!div_out_first_phase &&
        !div_out_second_phase && !div_out_index)
        else $error("open-collector value not low");
    a_zero_passes: assert property ($past(rst_b, 4) &&
        dip_sw == 8'h00 && $past(dip_sw) == 8'h00
        |-> div_out_first_phase_oe == !$past(enc_a))
        else $error("zero setting does not pass input");
    a_toggle_on_rise: assert property ($past(rst_b, 4) &&
        dip_sw != 8'h00 && $changed(div_out_first_phase_oe)
        |-> $past(enc_a, 2) && !$past(enc_a, 3))
        else $error("first phase moved without input rise");
    a_second_on_rise: assert property ($past(rst_b, 4) &&
        dip_sw != 8'h00 && $changed(div_out_second_phase_oe)
        |-> $past(enc_b, 2) && !$past(enc_b, 3))
        else $error("second phase moved without input rise");
    a_index_on_rise: assert property ($past(rst_b, 4) &&
        dip_sw != 8'h00 && $changed(div_out_index_oe)
        |-> $past(enc_z, 2) && !$past(enc_z, 3))
        else $error("index moved without input rise");
endmodule : epd_monitor
bind epd_top epd_monitor i_epd_monitor (.mclk, .rst_b, .enc_a, .enc_b,
    .enc_z, .dip_sw, .div_out_first_phase, .div_out_second_phase,
    .div_out_index, .div_out_first_phase_oe, .div_out_second_phase_oe,
    .div_out_index_oe, .wb_cyc, .wb_stb, .wb_ack);
`default_nettype wire

// [sim/epd_top_tb.sv]
// Bench for the encoder pulse divider: bus checks, then ratio sweeps.
// Assumes epd_top, epd_enc_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "epd_params.svh"
module epd_top_tb;
    import epd_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
    logic wb_we = 1'b0, start = 1'b0, wb_ack, busy;
    logic [31:0] wb_adr = 32'h0, wb_dat_w = 32'h0, wb_dat_r, rd;
    logic [7:0] dip_sw = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] exp_cnt;
    logic [7:0] sets [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
    logic [11:0] periods = 12'h000;
    wire epd_chan_type enc, pin, oe;
    epd_chan_type prev;
    int err_total = 0, samples_checked = 0, cnt [3];
    always #2.5 mclk = ~mclk;
    epd_top i_epd_top (.mclk, .rst_b, .enc_a(enc.first_phase),
        .enc_b(enc.second_phase), .enc_z(enc.index), .dip_sw,
        .div_out_first_phase(), .div_out_first_phase_oe(oe.first_phase),
        .div_out_first_phase_in(pin.first_phase), .div_out_second_phase(),
        .div_out_second_phase_oe(oe.second_phase),
        .div_out_second_phase_in(pin.second_phase), .div_out_index(),
        .div_out_index_oe(oe.index), .div_out_index_in(pin.index), .wb_cyc,
        .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack);
    epd_enc_model i_epd_enc_model (.mclk, .rst_b, .start, .periods, .oe,
        .enc, .pin, .busy);
    // Count changes on each divided channel
    always @(posedge mclk) begin
        prev <= oe;
        for (int i = 0; i < 3; i++) cnt[i] += int'(oe[i] !== prev[i]);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [3:0] s,
        input logic [31:0] a, d);
        @(posedge mclk);
        {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat_w} <= {2'b11, w, s, a, d};
        do @(posedge mclk); while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask : xfer
    task automatic reset_with(input logic [7:0] s);
        @(posedge mclk);
        {rst_b, dip_sw} <= {1'b0, s};
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask : reset_with
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // Register access, then one sweep per switch setting
    initial begin
        reset_with(8'h00);
        xfer(1'b0, 4'hF, `EPD_REG_CTRL, 32'h0);
        chk(rd, `EPD_CTRL_RESET);
        xfer(1'b1, 4'hF, 32'h0000_0008, 32'hFFFF_FFFF);
        xfer(1'b0, 4'hF, 32'h0000_0008, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, 4'hF, `EPD_REG_CTRL, 32'h0000_5501);
        xfer(1'b0, 4'hF, `EPD_REG_CTRL, 32'h0);
        chk(rd, 32'h0000_5501);
        // Lane 1 only: setting moves, enable and override keep
        xfer(1'b1, 4'h2, `EPD_REG_CTRL, 32'h0000_AA02);
        xfer(1'b0, 4'hF, `EPD_REG_CTRL, 32'h0);
        chk(rd, 32'h0000_AA01);
        // Override replaces the switches in the effective setting
        xfer(1'b1, 4'hF, `EPD_REG_CTRL, 32'h0000_3303);
        xfer(1'b0, 4'hF, `EPD_REG_STAT, 32'h0);
        chk(rd, 32'h0000_0033);
        foreach (sets[k]) begin
            reset_with(sets[k]);
            xfer(1'b0, 4'hF, `EPD_REG_STAT, 32'h0);
            chk(rd, {24'h0, sets[k]});
            cnt = '{0, 0, 0};
            start <= 1'b1;
            periods <= sets[k] == 8'h00 ? 12'h004 : {2'h0, sets[k], 2'h0};
            @(posedge mclk);
            start <= 1'b0;
            do @(posedge mclk); while (busy === 1'b1);
            repeat (8) @(posedge mclk);
            for (int i = 0; i < 3; i++) begin
                exp_cnt = sets[k] == `EPD_SET_NONE ? 32'h8 : 32'h4;
                chk(32'(cnt[i]), exp_cnt);
            end
        end
        end_of_test;
    end
    // Watchdog well past the longest sweep
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        end_of_test;
    end
endmodule : epd_top_tb
`default_nettype wire
